/* src/adsc_map.vh */
// constants for the adc/dac serial control block
// Summary of operation
// R1: Shift 16-bit serial words from host into parallel registers; SCLK up to 25MHz.
// R2: Serial input bit is sampled on each falling SCLK edge.
// R3: Host drives chip select low before clocking any command or data bits.
// R4: DAC write is command 0001XXXX, then two bytes giving channel and code.
// R5: Each DAC channel has an input register and a 12-bit output register.
// R6: Load strobe low or serial transfer sequence copies input into output registers.
// R7: DAC code is straight binary; one step is 1/4096 of reference.
// R8: Wake-up select low at power-up: codes 000h, buffers off, pulled to ground.
// R9: Wake-up select high at power-up: codes FFFh, buffers off, pulled to reference.
// R10: I/O write is command byte plus one data byte applied to I/O channels.
// R11: Internal oscillator runs and times conversions in clock modes 00, 01, 10.
// R12: In clock mode 11 host keeps SCLK 0.1-3.6MHz at 40-60% duty.
// R13: Reference 00 internal both after wake delay; 10 ADC internal, DAC first pin.
// R14: Reference 01 DAC first pin, ADC second pin; 11 ADC differential reference.
// R15: Second reference pin is analog input for 00/10, negative reference for 01/11.
// R16: Conversion command with bit 0 set requests one temperature conversion per scan.
// R17: Temperature converts first in scan and is read out as first two bytes.
// R18: New temperature result replaces an unread older temperature result.
// R19: Temperature uses internal reference; two's complement, 1/8 degree per step.
// R20: Scan starts on conversion write in modes 10/11, start pin pulse in 00/01.
// R21: Skip channels whose pin serves as conversion start or second reference.
// R22: Differential pairs ignore lowest channel select bit, converted as one channel.
// R23: Modes 00/01 one result per channel; 10 repeats by average count; 11 once. Code runs every scan as mode 11 in clock mode 11.
// R24: Scan mode 00 covers zero to selected; 01 selected to highest channel. Code converts selected channel only in clock mode 11.
// R25: Command byte with bit 7 set is a conversion register write.
// R26: Command byte with bit 7 clear and bit 6 set is a setup write.
// R27: Partial word is discarded when chip select returns high early.
`ifndef ADSC_MAP_VH
`define ADSC_MAP_VH
`define ADSC_SETUP_RST    8'h28
`define ADSC_CONV_RST     8'h00
`define ADSC_DAC_CMD      4'h1
`define ADSC_IO_CMD       8'h04
`define ADSC_OP_XFER_ALL  4'h8
`define ADSC_CODE_ZERO    12'h000
`define ADSC_CODE_FULL    12'hfff
`define ADSC_CONV_PIN_CH  3'h7
`define ADSC_SECOND_REFERENCE_PIN_CH      3'h6
`define ADSC_TOP_CH       3'h7
`define ADSC_AVG_BASE     6'h04
`define ADSC_REF_WAKE_CYC 8'hf4
`define ADSC_FIFO_DEPTH   5'h10
`define ADSC_PIN_RST      5'h19
`endif

/* src/adsc_core.v */
// serial control logic of the combined adc and quad dac
`timescale 1ns/1ps
`include "adsc_map.vh"

module adsc_core (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        cs_b,
    input  wire        sclk,
    input  wire        din,
    output wire        dout,
    input  wire        dac_load_strobe_b,
    input  wire        conversion_start_pin_b,
    input  wire        wakeup_level_select,
    input  wire [3:0]  diff_pair_mask,
    input  wire [1:0]  average_count,
    input  wire        conv_done,
    input  wire [11:0] conv_result,
    output wire [47:0] dac_code,
    output wire [3:0]  dac_buffer_on,
    output wire        dac_pull_to_ref,
    output wire [3:0]  io_out,
    output wire [1:0]  clock_mode_select,
    output wire [1:0]  reference_select,
    output wire [1:0]  diff_select,
    output wire        osc_enable,
    output wire        adc_ref_external,
    output wire        adc_ref_differential,
    output wire        dac_ref_external,
    output wire        second_reference_pin_is_input,
    output wire        conv_req,
    output wire [2:0]  conv_channel,
    output wire        conv_temp,
    output wire        conv_diff,
    output wire        conv_int_ref,
    output wire        scan_busy
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WAKE = 4'b0010;
    localparam [3:0] ST_REQ  = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    localparam [1:0] PH_CMD  = 2'h0;
    localparam [1:0] PH_HI   = 2'h1;
    localparam [1:0] PH_LO   = 2'h2;
    localparam [1:0] PH_IO   = 2'h3;

    function pair_of;
        input [2:0] ch;
        input [3:0] m;
        begin
            pair_of = m[ch[2:1]];
        end
    endfunction

    function [2:0] eff_ch;
        input [2:0] ch;
        input [3:0] m;
        begin
            eff_ch = pair_of(ch, m) ? {ch[2:1], 1'b0} : ch;
        end
    endfunction

    function covers;
        input [2:0] ch;
        input       d;
        input [2:0] pin;
        begin
            covers = (ch == pin) || (d && (ch[2:1] == pin[2:1]));
        end
    endfunction

    // pins: [4] conversion start, [3] load strobe, [2] data, [1] clock, [0] select
    wire [4:0] pin_raw = {conversion_start_pin_b, dac_load_strobe_b, din, sclk, cs_b};
    reg  [4:0] s1_r;
    reg  [4:0] s2_r;
    reg  [4:0] s3_r;
    reg  [4:0] pin_r;
    reg  [4:0] pin_old_r;
    wire [4:0] pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r      <= `ADSC_PIN_RST;
            s2_r      <= `ADSC_PIN_RST;
            s3_r      <= `ADSC_PIN_RST;
            pin_r     <= `ADSC_PIN_RST;
            pin_old_r <= `ADSC_PIN_RST;
        end else begin
            s1_r      <= pin_raw;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            pin_r     <= pin_nxt;
            pin_old_r <= pin_r;
        end
    end

    wire sel      = ~pin_r[0];
    wire sck_fall = pin_old_r[1] & ~pin_r[1];
    wire sck_rise = ~pin_old_r[1] & pin_r[1];
    wire sdi      = pin_r[2];
    wire load_low = ~pin_r[3];
    wire cnv_fall = pin_old_r[4] & ~pin_r[4];
    wire cs_fall  = pin_old_r[0] & ~pin_r[0];

    // serial command decode and register file
    reg  [2:0]  bit_cnt_r;
    reg  [6:0]  sh_r;
    reg  [1:0]  phase_r;
    reg  [7:0]  hi_r;
    reg  [7:0]  setup_r;
    reg  [7:0]  conv_r;
    reg         conv_wr_r;
    reg  [3:0]  io_r;
    reg  [11:0] dac_in_r [0:3];
    reg  [11:0] dac_out_r [0:3];
    reg  [3:0]  buf_on_r;
    reg         pull_ref_r;
    reg         init_pend_r;
    integer     i;

    wire        byte_done = sel & sck_fall & (bit_cnt_r == 3'h7); // [R2]
    wire [7:0]  rx_byte   = {sh_r, sdi};
    wire [15:0] rx_word   = {hi_r, rx_byte}; // [R1]
    wire [1:0]  rx_idx    = rx_word[13:12];

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_r   <= 3'h0;
            sh_r        <= 7'h00;
            phase_r     <= PH_CMD;
            hi_r        <= 8'h00;
            setup_r     <= `ADSC_SETUP_RST;
            conv_r      <= `ADSC_CONV_RST;
            conv_wr_r   <= 1'b0;
            io_r        <= 4'h0;
            buf_on_r    <= 4'h0;
            pull_ref_r  <= 1'b0;
            init_pend_r <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                dac_in_r[i]  <= `ADSC_CODE_ZERO;
                dac_out_r[i] <= `ADSC_CODE_ZERO;
            end
        end else if (init_pend_r) begin
            // strap caught at the first edge after release
            init_pend_r <= 1'b0;
            pull_ref_r  <= wakeup_level_select; // [R8] [R9]
            buf_on_r    <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                dac_in_r[i]  <= wakeup_level_select ? `ADSC_CODE_FULL : `ADSC_CODE_ZERO;
                dac_out_r[i] <= wakeup_level_select ? `ADSC_CODE_FULL : `ADSC_CODE_ZERO;
            end
        end else begin
            conv_wr_r <= 1'b0;
            if (!sel) begin
                bit_cnt_r <= 3'h0; // [R27]
                phase_r   <= PH_CMD;
            end else if (sck_fall) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                sh_r      <= {sh_r[5:0], sdi}; // [R2]
            end
            if (byte_done) begin
                case (phase_r)
                    PH_CMD: begin
                        if (rx_byte[7]) begin
                            conv_r    <= rx_byte; // [R25]
                            conv_wr_r <= 1'b1;
                        end else if (rx_byte[6]) begin
                            setup_r <= rx_byte; // [R26]
                        end else if (rx_byte[7:4] == `ADSC_DAC_CMD) begin
                            phase_r <= PH_HI; // [R4]
                        end else if (rx_byte == `ADSC_IO_CMD) begin
                            phase_r <= PH_IO; // [R10]
                        end
                    end
                    PH_HI: begin
                        hi_r    <= rx_byte;
                        phase_r <= PH_LO;
                    end
                    PH_LO: begin
                        phase_r <= PH_CMD;
                        if (rx_word[15:14] == 2'h0) begin
                            dac_in_r[rx_idx] <= rx_word[11:0]; // [R5]
                        end else if (rx_word[15:14] == 2'h1) begin
                            dac_in_r[rx_idx]  <= rx_word[11:0];
                            dac_out_r[rx_idx] <= rx_word[11:0]; // [R6]
                            buf_on_r[rx_idx]  <= 1'b1;
                        end else if (rx_word[15:12] == `ADSC_OP_XFER_ALL) begin
                            buf_on_r <= 4'hf;
                            for (i = 0; i < 4; i = i + 1) begin
                                dac_out_r[i] <= dac_in_r[i]; // [R6]
                            end
                        end
                    end
                    PH_IO: begin
                        io_r    <= rx_byte[3:0]; // [R10]
                        phase_r <= PH_CMD;
                    end
                    default: phase_r <= PH_CMD;
                endcase
            end
            if (load_low) begin
                buf_on_r <= 4'hf;
                for (i = 0; i < 4; i = i + 1) begin
                    dac_out_r[i] <= dac_in_r[i]; // [R6]
                end
            end
        end
    end

    // result storage: one temperature slot ahead of a channel fifo
    reg  [11:0] fifo_mem [0:15];
    reg  [3:0]  wr_ptr_r;
    reg  [3:0]  rd_ptr_r;
    reg  [4:0]  fifo_cnt_r;
    reg  [11:0] temp_r;
    reg         temp_vld_r;
    wire        res_push;
    wire        temp_set;
    wire        pop_temp = cs_fall & temp_vld_r;
    wire        pop_fifo = cs_fall & ~temp_vld_r & (fifo_cnt_r != 5'h00);
    wire        fifo_full = (fifo_cnt_r == `ADSC_FIFO_DEPTH);

    always @(posedge clk) begin
        if (res_push) begin
            fifo_mem[wr_ptr_r] <= conv_result;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r   <= 4'h0;
            rd_ptr_r   <= 4'h0;
            fifo_cnt_r <= 5'h00;
            temp_r     <= 12'h000;
            temp_vld_r <= 1'b0;
        end else begin
            if (res_push) begin
                wr_ptr_r <= wr_ptr_r + 4'h1;
            end
            if (pop_fifo || (res_push && fifo_full)) begin
                rd_ptr_r <= rd_ptr_r + 4'h1; // full: oldest result is dropped
            end
            if (res_push && !pop_fifo && !fifo_full) begin
                fifo_cnt_r <= fifo_cnt_r + 5'h01;
            end else if (pop_fifo && !res_push) begin
                fifo_cnt_r <= fifo_cnt_r - 5'h01;
            end
            if (temp_set) begin
                temp_r     <= conv_result; // [R18] [R19]
                temp_vld_r <= 1'b1;
            end else if (pop_temp) begin
                temp_vld_r <= 1'b0; // [R17]
            end
        end
    end

    // readout: word chosen at select fall, bits move after each rising clock that follows a falling clock
    reg  [15:0] tx_r;
    reg         dout_r;
    reg         seen_fall_r;
    wire [11:0] rd_data = temp_vld_r ? temp_r :
                          (fifo_cnt_r != 5'h00) ? fifo_mem[rd_ptr_r] : 12'h000;
    wire [15:0] rd_word = {4'h0, rd_data}; // [R17]

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_r        <= 16'h0000;
            dout_r      <= 1'b0;
            seen_fall_r <= 1'b0;
        end else if (cs_fall) begin
            dout_r      <= rd_word[15];
            tx_r        <= {rd_word[14:0], 1'b0};
            seen_fall_r <= 1'b0;
        end else if (sel) begin
            if (sck_fall) begin
                seen_fall_r <= 1'b1;
            end
            if (sck_rise && seen_fall_r) begin
                dout_r <= tx_r[15];
                tx_r   <= {tx_r[14:0], 1'b0};
            end
        end
    end

    // scan sequencer
    reg  [3:0] st_r;
    reg  [3:0] cur_r;
    reg  [2:0] end_r;
    reg  [5:0] rep_r;
    reg  [1:0] mode_r;
    reg        temp_pend_r;
    reg  [7:0] wcnt_r;
    reg        req_r;
    reg  [2:0] req_ch_r;
    reg        req_temp_r;
    reg        req_diff_r;
    reg        req_iref_r;

    wire [1:0] cks     = setup_r[5:4];
    wire [1:0] rsel    = setup_r[3:2];
    wire [2:0] sel_ch  = conv_r[5:3];
    wire [1:0] scan_md = conv_r[2:1];
    wire [1:0] md_eff  = (cks == 2'h3) ? 2'h3 : scan_md; // [R23]
    wire       start   = (st_r == ST_IDLE) &&
                         ((cks[1] && conv_wr_r) || (!cks[1] && cnv_fall)); // [R20]
    wire [2:0] e_ch    = eff_ch(cur_r[2:0], diff_pair_mask); // [R22]
    wire       e_d     = pair_of(cur_r[2:0], diff_pair_mask);
    wire       ch_ok   = !((!cks[1] && covers(e_ch, e_d, `ADSC_CONV_PIN_CH)) ||
                           (rsel[0] && covers(e_ch, e_d, `ADSC_SECOND_REFERENCE_PIN_CH))); // [R21]
    wire [3:0] nxt_ch  = {1'b0, e_ch} + (e_d ? 4'h2 : 4'h1);
    wire       last    = (mode_r == 2'h3) || ((mode_r == 2'h2) && (rep_r == 6'h01)) ||
                         (!mode_r[1] && (nxt_ch > {1'b0, end_r})); // [R23]

    assign res_push = (st_r == ST_WAIT) && conv_done && !req_temp_r;
    assign temp_set = (st_r == ST_WAIT) && conv_done && req_temp_r;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r        <= ST_IDLE;
            cur_r       <= 4'h0;
            end_r       <= 3'h0;
            rep_r       <= 6'h00;
            mode_r      <= 2'h3;
            temp_pend_r <= 1'b0;
            wcnt_r      <= 8'h00;
            req_r       <= 1'b0;
            req_ch_r    <= 3'h0;
            req_temp_r  <= 1'b0;
            req_diff_r  <= 1'b0;
            req_iref_r  <= 1'b0;
        end else begin
            req_r <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (start) begin
                        temp_pend_r <= conv_r[0]; // [R16]
                        mode_r      <= md_eff;
                        cur_r       <= {1'b0, (md_eff == 2'h0) ? 3'h0 : sel_ch}; // [R24]
                        end_r       <= (scan_md == 2'h1) ? `ADSC_TOP_CH : sel_ch;
                        rep_r       <= `ADSC_AVG_BASE << average_count; // [R23]
                        wcnt_r      <= `ADSC_REF_WAKE_CYC;
                        st_r        <= ((rsel == 2'h0) || conv_r[0]) ? ST_WAKE : ST_REQ; // [R13]
                    end
                end
                ST_WAKE: begin
                    wcnt_r <= wcnt_r - 8'h01;
                    if (wcnt_r == 8'h01) begin
                        st_r <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (temp_pend_r) begin
                        req_r      <= 1'b1; // [R17]
                        req_temp_r <= 1'b1;
                        req_diff_r <= 1'b0;
                        req_iref_r <= 1'b1; // [R19]
                        st_r       <= ST_WAIT;
                    end else if (ch_ok) begin
                        req_r      <= 1'b1;
                        req_ch_r   <= e_ch;
                        req_temp_r <= 1'b0;
                        req_diff_r <= e_d;
                        req_iref_r <= ~rsel[0];
                        st_r       <= ST_WAIT;
                    end else if (last || mode_r[1]) begin
                        st_r <= ST_IDLE; // [R21]
                    end else begin
                        cur_r <= nxt_ch;
                    end
                end
                ST_WAIT: begin
                    if (conv_done) begin
                        if (req_temp_r) begin
                            temp_pend_r <= 1'b0;
                            st_r        <= ST_REQ;
                        end else if (last) begin
                            st_r <= ST_IDLE;
                        end else begin
                            st_r <= ST_REQ;
                            if (mode_r == 2'h2) begin
                                rep_r <= rep_r - 6'h01;
                            end else begin
                                cur_r <= nxt_ch; // [R24]
                            end
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    assign dout                 = dout_r;
    assign dac_code             = {dac_out_r[3], dac_out_r[2], dac_out_r[1], dac_out_r[0]}; // [R7]
    assign dac_buffer_on        = buf_on_r;
    assign dac_pull_to_ref      = pull_ref_r;
    assign io_out               = io_r;
    assign clock_mode_select    = cks;
    assign reference_select     = rsel;
    assign diff_select          = setup_r[1:0];
    assign osc_enable           = (cks != 2'h3); // [R11]
    assign adc_ref_external     = rsel[0]; // [R14]
    assign adc_ref_differential = (rsel == 2'h3); // [R14]
    assign dac_ref_external     = (rsel != 2'h0); // [R13]
    assign second_reference_pin_is_input        = ~rsel[0]; // [R15]
    assign conv_req             = req_r;
    assign conv_channel         = req_ch_r;
    assign conv_temp            = req_temp_r;
    assign conv_diff            = req_diff_r;
    assign conv_int_ref         = req_iref_r;
    assign scan_busy            = (st_r != ST_IDLE);

endmodule // adsc_core

/* verif/adsc_chk.sv */
// port assertions for the serial control block
`timescale 1ns/1ps
module adsc_chk (
    input logic        clk,
    input logic        rst_b,
    input logic        wakeup_level_select,
    input logic [3:0]  diff_pair_mask,
    input logic [47:0] dac_code,
    input logic [3:0]  dac_buffer_on,
    input logic        dac_pull_to_ref,
    input logic [1:0]  clock_mode_select,
    input logic [1:0]  reference_select,
    input logic        osc_enable,
    input logic        adc_ref_external,
    input logic        adc_ref_differential,
    input logic        dac_ref_external,
    input logic        second_reference_pin_is_input,
    input logic        conv_req,
    input logic [2:0]  conv_channel,
    input logic        conv_temp,
    input logic        conv_diff,
    input logic        conv_int_ref,
    input logic        scan_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic first_r;
    // high until the first request of a scan has gone out
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) first_r <= 1'b1;
        else if (!scan_busy) first_r <= 1'b1;
        else if (conv_req) first_r <= 1'b0;
    end
    sequence s_release;
        $rose(rst_b);
    endsequence
    sequence s_wake_state;
        dac_code == {4{wakeup_level_select ? 12'hfff : 12'h000}} && dac_buffer_on == 4'h0
            && dac_pull_to_ref == wakeup_level_select;
    endsequence
    property p_wake;
        s_release |=> s_wake_state;
    endproperty
    property p_osc;
        osc_enable == (clock_mode_select != 2'b11);
    endproperty
    property p_ref;
        {adc_ref_external, adc_ref_differential, dac_ref_external} ==
            {reference_select[0], reference_select == 2'b11, reference_select != 2'b00};
    endproperty
    property p_second_reference_pin;
        second_reference_pin_is_input == !reference_select[0];
    endproperty
    property p_start;
        !scan_busy |-> !conv_req;
    endproperty
    property p_pulse;
        conv_req |=> !conv_req;
    endproperty
    property p_temp_first;
        conv_req && !first_r |-> !conv_temp;
    endproperty
    property p_temp_ref;
        conv_req |-> conv_int_ref == (conv_temp || !reference_select[0]);
    endproperty
    property p_skip;
        conv_req && !conv_temp |-> !(conv_channel == 3'h6 && reference_select[0])
            && !(conv_channel == 3'h7 && !clock_mode_select[1]);
    endproperty
    property p_diff;
        conv_req && conv_diff |-> !conv_channel[0] && diff_pair_mask[conv_channel[2:1]];
    endproperty
    a_wake: assert property (p_wake) else $error("dac wake state wrong");
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");
    a_ref: assert property (p_ref) else $error("reference routing wrong");
    a_second_reference_pin: assert property (p_second_reference_pin) else $error("second reference use wrong");
    a_start: assert property (p_start) else $error("request while idle");
    a_pulse: assert property (p_pulse) else $error("request longer than a cycle");
    a_temp_first: assert property (p_temp_first) else $error("temperature not first");
    a_temp_ref: assert property (p_temp_ref) else $error("request ref wrong");
    a_skip: assert property (p_skip) else $error("conflicting channel used");
    a_diff: assert property (p_diff) else $error("bad differential request");
endmodule // adsc_chk

bind adsc_core adsc_chk u_adsc_chk (.*);

/* verif/adsc_host.sv */
// host serial master model driving the device pins
`timescale 1ns/1ps
module adsc_host (
    input  logic clk,
    input  logic dout,
    output logic cs_b,
    output logic sclk,
    output logic din
);
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // 2.5 mhz, 50 percent duty; dout taken at the end of each low phase
    task automatic xfer(input logic [23:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0;
        wt(1);
        cs_b = 1'b0;
        wt(8);
        for (int i = n - 1; i >= 0; i--) begin
            din  = tx[i];
            sclk = 1'b1;
            wt(4);
            sclk = 1'b0;
            wt(4);
            rx = {rx[14:0], dout};
        end
        cs_b = 1'b1;
        din  = ~din;
        wt(8);
    endtask
endmodule // adsc_host

/* verif/testbench.sv */
// self-checking bench for the serial control block
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_b, cs_b, sclk, din, dout, conv_done, conv_req, scan_busy;
    logic        dac_load_strobe_b, conversion_start_pin_b, wakeup_level_select;
    logic        dac_pull_to_ref, osc_enable, adc_ref_external, adc_ref_differential;
    logic        dac_ref_external, second_reference_pin_is_input, conv_temp, conv_diff, conv_int_ref;
    logic [1:0]  average_count, clock_mode_select, reference_select, diff_select;
    logic [2:0]  conv_channel;
    logic [3:0]  diff_pair_mask, dac_buffer_on, io_out;
    logic [11:0] conv_result, res_n;
    logic [15:0] rx;
    logic [47:0] dac_code;
    logic [4:0]  log_q[$];
    int          miscompares, checked, dly;

    adsc_core u_adsc_core (.*);
    adsc_host u_adsc_host (.*);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // converter stand-in: logs each request, answers three cycles later
    always @(negedge clk) begin
        conv_done <= 1'b0;
        if (conv_req === 1'b1) begin
            log_q.push_back({conv_temp, conv_diff, conv_channel});
            dly <= 3;
        end else if (dly > 0) begin
            dly <= dly - 1;
            if (dly == 1) begin
                conv_done   <= 1'b1;
                conv_result <= res_n;
                res_n       <= res_n + 12'h001;
            end
        end
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reqs(input int n, input logic [39:0] e);
        chk(48'(log_q.size()), 48'(n));
        for (int i = 0; i < n && i < log_q.size(); i++) chk(48'(log_q[i]), 48'(e[5*(n-1-i) +: 5]));
        log_q.delete();
    endtask
    task automatic wait_idle;
        int k;
        repeat (4) @(negedge clk);
        for (k = 0; scan_busy !== 1'b0 && k < 2000; k++) @(negedge clk);
        chk(48'(k < 2000), 48'h1);
    endtask
    task automatic scan(input logic [7:0] cmd);
        u_adsc_host.xfer({16'h0, cmd}, 8, rx);
        wait_idle();
    endtask
    task automatic rd(input logic [15:0] exp);
        u_adsc_host.xfer(24'h0, 16, rx);
        chk(48'(rx), 48'(exp));
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        chk(48'h0, 48'h1); // timeout
        finish_test();
    end
    initial begin
        rst_b = 1'b0; dac_load_strobe_b = 1'b1; conversion_start_pin_b = 1'b1;
        wakeup_level_select = 1'b0; diff_pair_mask = 4'h0; average_count = 2'h0;
        conv_done = 1'b0; conv_result = 12'h000; res_n = 12'h100; dly = 0;
        miscompares = 0; checked = 0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk(dac_code, 48'h0);
        chk(48'({dac_buffer_on, dac_pull_to_ref}), 48'h0);
        chk(48'({clock_mode_select, reference_select, osc_enable}), 48'h15);
        $display("test reset done");
        repeat (2) begin
            scan(8'h87);
            reqs(2, {30'h0, 5'h10, 5'h00});
        end
        rd(16'h0102);
        rd(16'h0101);
        rd(16'h0103);
        rd(16'h0000);
        $display("test temperature done");
        for (int k = 0; k < 4; k++) begin
            u_adsc_host.xfer({16'h0, 2'b01, k[1:0], k[1:0], 2'b00}, 8, rx);
            chk(48'({clock_mode_select, reference_select, osc_enable, adc_ref_external,
                adc_ref_differential, dac_ref_external, second_reference_pin_is_input}),
                48'({k[1:0], k[1:0], k != 3, k[0], k == 3, k != 0, !k[0]}));
        end
        scan(8'h90);
        reqs(1, {35'h0, 5'h02});
        u_adsc_host.xfer(24'h00000c, 5, rx);
        chk(48'({clock_mode_select, reference_select}), 48'hf);
        u_adsc_host.xfer(24'h6b040a, 24, rx);
        chk(48'({io_out, reference_select, diff_select}), 48'hab);
        $display("test setup done");
        u_adsc_host.xfer(24'h100abc, 24, rx);
        chk(dac_code, 48'h0);
        dac_load_strobe_b = 1'b0;
        repeat (8) @(negedge clk);
        dac_load_strobe_b = 1'b1;
        repeat (8) @(negedge clk);
        chk(dac_code, 48'habc);
        u_adsc_host.xfer(24'h1f6123, 24, rx);
        chk(dac_code, 48'h000123000abc);
        chk(48'(dac_buffer_on[2]), 48'h1);
        u_adsc_host.xfer(24'h101555, 24, rx);
        u_adsc_host.xfer(24'h108000, 24, rx);
        chk(dac_code, 48'h000123555abc);
        chk(48'(dac_buffer_on), 48'hf);
        $display("test dac done");
        scan(8'h90);
        reqs(3, {25'h0, 5'h00, 5'h01, 5'h02});
        scan(8'haa);
        reqs(3, {25'h0, 5'h05, 5'h06, 5'h07});
        average_count = 2'h1;
        scan(8'h9c);
        reqs(8, {8{5'h03}});
        diff_pair_mask = 4'h2;
        scan(8'h98);
        reqs(3, {25'h0, 5'h00, 5'h01, 5'h0a});
        diff_pair_mask = 4'h0;
        u_adsc_host.xfer(24'h000064, 8, rx);
        scan(8'haa);
        reqs(2, {30'h0, 5'h05, 5'h07});
        u_adsc_host.xfer(24'h000048, 8, rx);
        scan(8'h86);
        reqs(0, 40'h0);
        conversion_start_pin_b = 1'b0;
        repeat (10) @(negedge clk);
        conversion_start_pin_b = 1'b1;
        wait_idle();
        reqs(1, {35'h0, 5'h00});
        $display("test scan done");
        rst_b = 1'b0;
        wakeup_level_select = 1'b1;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk(dac_code, {4{12'hfff}});
        chk(48'({dac_buffer_on, dac_pull_to_ref}), 48'h1);
        $display("test wake high done");
        finish_test();
    end
endmodule // testbench
